// ### logic/dcs_top.sv
// design: global control, table base and interrupt status of the dma controller
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module dcs_top #(
    parameter int CHAN_N = dcs_pkg::DCS_CHAN_N
) (
    input  wire logic                         sys_clk_in,
    input  wire logic                         srst_in,
    input  wire dcs_pkg::dcs_bus_req_type     bus_req_in,
    output logic [dcs_pkg::DCS_DATA_W-1:0]    bus_rdata_out,
    input  wire dcs_pkg::dcs_engine_evt_type  engine_evt_in,
    output logic                              engine_run_out,
    output logic [CHAN_N-1:0]                 chan_active_out,
    output logic [31:0]                       control_table_base_pointer_out,
    output logic                              irq_out,
    output logic                              err_irq_out
);
    import dcs_pkg::*;

    // ****************************************
    // state
    // ****************************************
    dcs_state_type           state;
    dcs_state_type           next_state;
    logic [31:0]             control_table_base_pointer;
    logic [31:0]             next_control_table_base_pointer;
    logic [CHAN_N-1:0]       chan_en;
    logic [CHAN_N-1:0]       next_chan_en;
    logic [CHAN_N-1:0]       chan_stop;
    logic [CHAN_N-1:0]       next_chan_stop;
    logic [CHAN_N-1:0]       channel_interrupt_status;
    logic [CHAN_N-1:0]       next_channel_interrupt_status;
    logic [CHAN_N-1:0]       chan_mask;
    logic [CHAN_N-1:0]       next_chan_mask;
    logic                    err_pending;
    logic                    next_err_pending;
    logic                    err_mask;
    logic                    next_err_mask;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic                    running;
    logic [CHAN_N-1:0]       done_q;
    logic [CHAN_N-1:0]       channel_clear_mask;
    logic                    ctrl_wr;
    logic                    base_wr;
    logic                    chan_en_wr;
    logic                    chan_mask_wr;
    logic                    err_mask_wr;
    logic                    err_clr;
    logic                    err_set;
    logic [CHAN_N-1:0]       chan_irq_hits;
    logic [31:0]             ctrl_word;
    logic [31:0]             chan_en_word;
    logic [31:0]             chan_stop_word;
    logic [31:0]             err_word;
    logic [31:0]             chan_irq_word;
    logic [31:0]             chan_mask_word;
    logic [31:0]             err_mask_word;

    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic hit(input logic [7:0] ofs, input dcs_bus_req_type r);
        return r.addr == ofs;
    endfunction

    // half-way point of the table, sized from the channel count
    function automatic logic [31:0] alt_base(input logic [31:0] base);
        return base + 32'(CHAN_N * 16);
    endfunction

    // channel vectors widened to one bus word
    function automatic logic [31:0] pad_word(input logic [CHAN_N-1:0] v);
        return 32'(v);
    endfunction

    // ****************************************
    // event qualification
    // ****************************************
    // gated engine
    assign running  = (state == DCS_RUN);
    assign done_q   = running ? engine_evt_in.done[CHAN_N-1:0] & chan_en : '0;
    assign channel_clear_mask = (bus_req_in.wr && hit(DCS_OFS_CH_IRQ, bus_req_in))
                                ? bus_req_in.wdata[CHAN_N-1:0] : '0;

    // ****************************************
    // write decode
    // ****************************************
    assign ctrl_wr      = bus_req_in.wr && hit(DCS_OFS_CTRL, bus_req_in);
    assign base_wr      = bus_req_in.wr && hit(DCS_OFS_BASE, bus_req_in);
    assign chan_en_wr   = bus_req_in.wr && hit(DCS_OFS_CH_EN, bus_req_in);
    assign chan_mask_wr = bus_req_in.wr && hit(DCS_OFS_CH_MASK, bus_req_in);
    assign err_mask_wr  = bus_req_in.wr && hit(DCS_OFS_ERR_MASK, bus_req_in);
    assign err_clr      = bus_req_in.wr && hit(DCS_OFS_ERR, bus_req_in) && bus_req_in.wdata[DCS_ERR_BIT];
    assign err_set      = running && engine_evt_in.error;

    // ****************************************
    // readable words
    // ****************************************
    assign ctrl_word      = {31'h0000_0000, running};
    assign chan_en_word   = pad_word(chan_en);
    assign chan_stop_word = pad_word(chan_stop);
    assign err_word       = {31'h0000_0000, err_pending};
    assign chan_irq_word  = pad_word(channel_interrupt_status);
    assign chan_mask_word = pad_word(chan_mask);
    assign err_mask_word  = {31'h0000_0000, err_mask};

    // ****************************************
    // global enable
    // ****************************************
    // disable freezes channel state rather than clearing it
    always_comb begin
        next_state = state;
        case (state)
            DCS_OFF: begin
                if (ctrl_wr && bus_req_in.wdata[DCS_CTRL_EN_BIT]) begin
                    next_state = DCS_RUN;
                end
            end
            DCS_RUN: begin
                if (ctrl_wr && !bus_req_in.wdata[DCS_CTRL_EN_BIT]) begin
                    next_state = DCS_OFF;
                end
            end
            default: begin
                next_state = DCS_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state <= DCS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // table base
    // ****************************************
    // low bits forced to zero keep the table on its boundary
    always_comb begin
        next_control_table_base_pointer = control_table_base_pointer;
        if (base_wr) begin
            next_control_table_base_pointer = {bus_req_in.wdata[31:DCS_ALIGN_BITS], DCS_ALIGN_BITS'(0)};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            control_table_base_pointer <= DCS_RST_BASE;
        end else begin
            control_table_base_pointer <= next_control_table_base_pointer;
        end
    end

    // ****************************************
    // channel enable and stop mode
    // ****************************************
    // a completion beats an enable write in the same cycle
    always_comb begin
        next_chan_en   = chan_en;
        next_chan_stop = chan_stop;
        if (chan_en_wr) begin
            next_chan_en   = chan_en | bus_req_in.wdata[CHAN_N-1:0];
            next_chan_stop = chan_stop & ~bus_req_in.wdata[CHAN_N-1:0];
        end
        next_chan_en   = next_chan_en & ~done_q;
        next_chan_stop = next_chan_stop | done_q;
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            chan_en   <= '0;
            chan_stop <= '0;
        end else begin
            chan_en   <= next_chan_en;
            chan_stop <= next_chan_stop;
        end
    end

    // ****************************************
    // channel interrupt status
    // ****************************************
    always_comb begin
        next_channel_interrupt_status = (channel_interrupt_status & ~channel_clear_mask) | done_q;
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            channel_interrupt_status <= '0;
        end else begin
            channel_interrupt_status <= next_channel_interrupt_status;
        end
    end

    // ****************************************
    // channel interrupt mask
    // ****************************************
    always_comb begin
        next_chan_mask = chan_mask;
        if (chan_mask_wr) begin
            next_chan_mask = bus_req_in.wdata[CHAN_N-1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            chan_mask <= '0;
        end else begin
            chan_mask <= next_chan_mask;
        end
    end

    // ****************************************
    // error status
    // ****************************************
    always_comb begin
        next_err_pending = err_pending;
        if (err_clr) begin
            next_err_pending = 1'b0;
        end
        if (err_set) begin
            next_err_pending = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            err_pending <= 1'b0;
        end else begin
            err_pending <= next_err_pending;
        end
    end

    // ****************************************
    // error mask
    // ****************************************
    always_comb begin
        next_err_mask = err_mask;
        if (err_mask_wr) begin
            next_err_mask = bus_req_in.wdata[DCS_ERR_BIT];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            err_mask <= 1'b0;
        end else begin
            err_mask <= next_err_mask;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        next_rdata = DCS_RST_ZERO;
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                DCS_OFS_CTRL:     next_rdata = ctrl_word;
                DCS_OFS_BASE:     next_rdata = control_table_base_pointer;
                DCS_OFS_ALT_BASE: next_rdata = alt_base(control_table_base_pointer);
                DCS_OFS_CH_EN:    next_rdata = chan_en_word;
                DCS_OFS_CH_STOP:  next_rdata = chan_stop_word;
                DCS_OFS_ERR:      next_rdata = err_word;
                DCS_OFS_CH_IRQ:   next_rdata = chan_irq_word;
                DCS_OFS_CH_MASK:  next_rdata = chan_mask_word;
                DCS_OFS_ERR_MASK: next_rdata = err_mask_word;
                DCS_OFS_ID:       next_rdata = DCS_ID_VALUE;
                default:          next_rdata = DCS_RST_ZERO;
            endcase
        end
    end

    // ****************************************
    // read data register
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rdata <= DCS_RST_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // outputs and interrupts
    // ****************************************
    assign bus_rdata_out                  = rdata;
    assign engine_run_out                 = running;
    assign chan_active_out                = running ? chan_en : '0;
    assign control_table_base_pointer_out = control_table_base_pointer;
    assign chan_irq_hits                  = channel_interrupt_status & chan_mask;
    assign err_irq_out                    = err_pending & err_mask;
    assign irq_out                        = |chan_irq_hits | err_irq_out;
endmodule

// ### logic/dcs_pkg.sv
// package: constants, register map and carrier types of the dma control/status front end
//
// Overview of operation
// - the alternate structures start at the upper half of the table and that address is readable.
// - channel control lives in system memory and the written base address reads back with its low 10 bits cleared.
// - with the global enable off no operation happens until the enable is set again.
// - a transfer error raises the error interrupt and the error status reads non-zero while pending.
// - a software clear of the error status removes the pending error so it reads zero.
// - a 32-bit channel interrupt status has one bit per channel and many bits may be set.
// - a clear with a 32-bit channel mask clears each masked status bit and leaves the others.
// - on completion a channel disables itself and its mode becomes stop.
package dcs_pkg;
    localparam int          DCS_ADDR_W       = 8;
    localparam int          DCS_DATA_W       = 32;
    localparam int          DCS_CHAN_N       = 32;
    localparam int          DCS_TABLE_ALIGN  = 1024;
    localparam int          DCS_ALIGN_BITS   = $clog2(DCS_TABLE_ALIGN);

    // register offsets (byte addresses)
    localparam logic [7:0]  DCS_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  DCS_OFS_BASE     = 8'h04;
    localparam logic [7:0]  DCS_OFS_ALT_BASE = 8'h08;
    localparam logic [7:0]  DCS_OFS_CH_EN    = 8'h0c;
    localparam logic [7:0]  DCS_OFS_CH_STOP  = 8'h10;
    localparam logic [7:0]  DCS_OFS_ERR      = 8'h14;
    localparam logic [7:0]  DCS_OFS_CH_IRQ   = 8'h18;
    localparam logic [7:0]  DCS_OFS_CH_MASK  = 8'h1c;
    localparam logic [7:0]  DCS_OFS_ERR_MASK = 8'h20;
    localparam logic [7:0]  DCS_OFS_ID       = 8'h24;

    // field positions
    localparam int          DCS_CTRL_EN_BIT  = 0;
    localparam int          DCS_ERR_BIT      = 0;

    // reset values
    localparam logic [31:0] DCS_RST_BASE     = 32'h0000_0000;
    localparam logic [31:0] DCS_RST_ZERO     = 32'h0000_0000;
    // arbitrary identity value
    localparam logic [31:0] DCS_ID_VALUE     = 32'h0000_a5a5;

    typedef struct packed {
        logic [DCS_ADDR_W-1:0] addr;
        logic [DCS_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } dcs_bus_req_type;

    typedef struct packed {
        logic [DCS_CHAN_N-1:0] done;
        logic                  error;
    } dcs_engine_evt_type;

    typedef enum logic [1:0] {
        DCS_OFF,
        DCS_RUN
    } dcs_state_type;
endpackage

// ### tb/dcs_props.sv
// checker: port relations of the dma control/status front end
`timescale 1ns/1ps
module dcs_props #(parameter int CHAN_N = 32) (
    input wire logic                        sys_clk_in,
    input wire logic                        srst_in,
    input wire dcs_pkg::dcs_bus_req_type    bus_req_in,
    input wire logic [31:0]                 bus_rdata_out,
    input wire dcs_pkg::dcs_engine_evt_type engine_evt_in,
    input wire logic                        engine_run_out,
    input wire logic [CHAN_N-1:0]           chan_active_out,
    input wire logic [31:0]                 control_table_base_pointer_out,
    input wire logic                        irq_out,
    input wire logic                        err_irq_out
);
    import dcs_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    wire logic wr = bus_req_in.wr;
    wire logic [7:0] ad = bus_req_in.addr;
    wire logic hit = engine_run_out && |(engine_evt_in.done & chan_active_out);
    property p_base; wr && ad == DCS_OFS_BASE
        |=> control_table_base_pointer_out == ($past(bus_req_in.wdata) & 32'hffff_fc00); endproperty
    a_base: assert property (p_base) else $error("table base not stored aligned");
    property p_alt; bus_req_in.rd && ad == DCS_OFS_ALT_BASE
        |=> bus_rdata_out == control_table_base_pointer_out + CHAN_N * 16; endproperty
    a_alt: assert property (p_alt) else $error("alternate base wrong");
    property p_off; !engine_run_out |-> chan_active_out == '0; endproperty
    a_off: assert property (p_off) else $error("channel active while off");
    property p_en; wr && ad == DCS_OFS_CTRL && bus_req_in.wdata[0] |=> engine_run_out; endproperty
    a_en: assert property (p_en) else $error("enable not taken");
    property p_eclr; wr && ad == DCS_OFS_ERR && bus_req_in.wdata[0] && !engine_evt_in.error
        |=> !err_irq_out; endproperty
    a_eclr: assert property (p_eclr) else $error("error not cleared");
    property p_iclr; wr && ad == DCS_OFS_CH_IRQ && bus_req_in.wdata == 32'hffff_ffff
        && engine_evt_in == '0 |=> irq_out == err_irq_out; endproperty
    a_iclr: assert property (p_iclr) else $error("channel status not cleared");
    property p_done; hit && !wr |=> (chan_active_out & $past(engine_evt_in.done)) == '0; endproperty
    a_done: assert property (p_done) else $error("channel still active after done");
    property p_rst; $fell(srst_in) |-> !engine_run_out && !irq_out && !err_irq_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    c_irq: cover property (irq_out);
    c_err: cover property (err_irq_out);
    c_hit: cover property (hit);
endmodule

// ### tb/dcs_top_tb.sv
// testbench: register and event scenarios of the dma control/status front end
`timescale 1ns/1ps
module dcs_top_tb;
    import dcs_pkg::*;
    logic               sys_clk_in = 1'b0;
    logic               srst_in = 1'b1;
    dcs_bus_req_type    bus_req_in = '0;
    dcs_engine_evt_type engine_evt_in = '0;
    logic [31:0]        rdata, base_ptr, act;
    logic               run, irq, err_irq;
    int                 miscompares = 0;
    int                 checks_done = 0;
    always #2 sys_clk_in = ~sys_clk_in;
    dcs_top dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .bus_req_in(bus_req_in), .bus_rdata_out(rdata),
        .engine_evt_in(engine_evt_in), .engine_run_out(run), .chan_active_out(act),
        .control_table_base_pointer_out(base_ptr), .irq_out(irq), .err_irq_out(err_irq));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus_req_in <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        bus_req_in <= '0;
        @(posedge sys_clk_in);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus_req_in <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        bus_req_in <= '0;
        #1 chk(rdata, exp);
        @(posedge sys_clk_in);
    endtask
    task evt(input logic [31:0] dn, input logic er);
        engine_evt_in <= '{dn, er};
        @(posedge sys_clk_in);
        engine_evt_in <= '0;
        @(posedge sys_clk_in);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset_vals;
        rd(DCS_OFS_CTRL, 32'h0);
        rd(DCS_OFS_CH_IRQ, 32'h0);
        rd(DCS_OFS_ERR, 32'h0);
        $display("reset values done");
    endtask
    task t_base;
        wr(DCS_OFS_BASE, 32'h2000_0400);
        rd(DCS_OFS_BASE, 32'h2000_0400);
        chk(base_ptr, 32'h2000_0400);
        rd(DCS_OFS_ALT_BASE, 32'h2000_0400 + 32'(DCS_CHAN_N * 16));
        $display("base done");
    endtask
    task t_events;
        wr(DCS_OFS_CTRL, 32'h1);
        wr(DCS_OFS_CH_EN, 32'h28);
        wr(DCS_OFS_CH_MASK, 32'h8);
        evt(32'h28, 1'b0);
        rd(DCS_OFS_CH_IRQ, 32'h28);
        rd(DCS_OFS_CH_EN, 32'h0);
        rd(DCS_OFS_CH_STOP, 32'h28);
        chk({31'h0, irq}, 32'h1);
        wr(DCS_OFS_CH_IRQ, 32'h8);
        rd(DCS_OFS_CH_IRQ, 32'h20);
        chk({31'h0, irq}, 32'h0);
        wr(DCS_OFS_CH_IRQ, 32'hffff_ffff);
        rd(DCS_OFS_CH_IRQ, 32'h0);
        rd(8'hfc, 32'h0);
        $display("events done");
    endtask
    task t_error;
        wr(DCS_OFS_ERR_MASK, 32'h1);
        evt(32'h0, 1'b1);
        rd(DCS_OFS_ERR, 32'h1);
        chk({30'h0, err_irq, irq}, 32'h3);
        wr(DCS_OFS_ERR, 32'h1);
        rd(DCS_OFS_ERR, 32'h0);
        chk({31'h0, err_irq}, 32'h0);
        $display("error done");
    endtask
    task t_disable;
        wr(DCS_OFS_CH_EN, 32'h1);
        wr(DCS_OFS_CTRL, 32'h0);
        chk({act[30:0], run}, 32'h0);
        evt(32'h1, 1'b1);
        rd(DCS_OFS_CH_IRQ, 32'h0);
        rd(DCS_OFS_ERR, 32'h0);
        wr(DCS_OFS_CTRL, 32'h1);
        chk(act, 32'h1);
        evt(32'h1, 1'b0);
        rd(DCS_OFS_CH_IRQ, 32'h1);
        $display("disable done");
    endtask
    task t_rerun;
        evt(32'h0, 1'b1);
        chk({31'h0, err_irq}, 32'h1);
        srst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        @(posedge sys_clk_in);
        chk({30'h0, err_irq, run}, 32'h0);
        rd(DCS_OFS_CH_EN, 32'h0);
        rd(DCS_OFS_CH_IRQ, 32'h0);
        rd(DCS_OFS_BASE, DCS_RST_BASE);
        $display("reset rerun done");
    endtask
    initial begin
        repeat (2000) @(posedge sys_clk_in);
        miscompares++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        @(posedge sys_clk_in);
        t_reset_vals;
        t_base;
        t_events;
        t_error;
        t_disable;
        t_rerun;
        test_done;
    end
endmodule
bind dcs_top dcs_props #(.CHAN_N(CHAN_N)) u_props (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .engine_evt_in(engine_evt_in),
    .engine_run_out(engine_run_out), .chan_active_out(chan_active_out),
    .control_table_base_pointer_out(control_table_base_pointer_out), .irq_out(irq_out), .err_irq_out(err_irq_out));
